// file: rtl/shutdown_pkg.sv
// shared constants for the emergency port shutdown block
package shutdown_pkg;
    localparam int unsigned CLK_MHZ          = 250;
    // bit period in microseconds: min, nominal, max
    localparam int unsigned BIT_MIN_US       = 24;
    localparam int unsigned BIT_NOM_US       = 25;
    localparam int unsigned BIT_MAX_US       = 26;
    localparam int unsigned OFF_MAX_US       = 50;
    localparam int unsigned IDLE_MIN_US      = 125;
    localparam int unsigned BIT_CYCLES       = BIT_NOM_US * CLK_MHZ;
    localparam int unsigned HALF_BIT_CYCLES  = BIT_CYCLES / 2;
    localparam int unsigned OFF_MAX_CYCLES   = OFF_MAX_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 16;
    localparam int unsigned PRIO_W           = 3;
    localparam int unsigned CODE_BITS        = 3;
    localparam int unsigned NUM_PORTS        = 8;
    // axi-lite register byte addresses
    localparam logic [7:0] ADDR_CONFIG       = 8'h00;
    localparam logic [7:0] ADDR_LOW_PRIO     = 8'h04;
    localparam logic [7:0] ADDR_PRIO_LEVEL   = 8'h08;
    localparam logic [7:0] ADDR_POWER_ON     = 8'h0c;
    localparam logic [7:0] ADDR_ALLOW        = 8'h10;
    localparam logic [7:0] ADDR_STATUS       = 8'h14;
    localparam logic [7:0] ADDR_LAST_CODE    = 8'h18;
    localparam logic [1:0] RESP_OKAY         = 2'b00;
    localparam logic [1:0] RESP_SLVERR       = 2'b10;
    localparam int unsigned CFG_CODED_BIT    = 0;
endpackage

// file: rtl/shutdown_code_receiver.sv
// serial shutdown code receiver: start marker then three bits msb first
`timescale 1ns/1ps
module shutdown_code_receiver #(
    parameter int unsigned BIT_CYCLES = shutdown_pkg::BIT_CYCLES
) (
    // clock and reset
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // line and mode
    input  wire logic                            enable,
    input  wire logic                            line_in,
    // decoded code
    output logic                                 code_valid,
    output logic [shutdown_pkg::PRIO_W-1:0]      code_value
);
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA
    } rx_state_type;

    typedef struct packed {
        rx_state_type                         state;
        logic [shutdown_pkg::CNT_W-1:0]       cnt;
        logic [1:0]                           bit_idx;
        logic [shutdown_pkg::PRIO_W-1:0]      shift;
        logic                                 line_prev;
        logic                                 valid;
        logic [shutdown_pkg::PRIO_W-1:0]      value;
    } rx_type;

    localparam logic [shutdown_pkg::CNT_W-1:0] FULL_BIT =
        shutdown_pkg::CNT_W'(BIT_CYCLES - 1);
    localparam logic [shutdown_pkg::CNT_W-1:0] HALF_BIT =
        shutdown_pkg::CNT_W'(BIT_CYCLES / 2 - 1);
    localparam logic [1:0] LAST_IDX = 2'(shutdown_pkg::CODE_BITS - 1);

    rx_type rx_q;
    rx_type rx_d;

    always_comb begin
        rx_d           = rx_q;
        rx_d.valid     = 1'b0;
        rx_d.line_prev = line_in;
        unique case (rx_q.state)
            RX_IDLE: begin
                // marker rising edge; sample its middle half a period later
                if (enable && line_in && !rx_q.line_prev) begin
                    rx_d.state = RX_START;
                    rx_d.cnt   = HALF_BIT;
                end
            end
            RX_START: begin
                if (rx_q.cnt != '0) begin
                    rx_d.cnt = rx_q.cnt - 1'b1;
                end else if (line_in) begin
                    rx_d.state   = RX_DATA;
                    rx_d.cnt     = FULL_BIT;
                    rx_d.bit_idx = '0;
                end else begin
                    // glitch, not a marker
                    rx_d.state = RX_IDLE;
                end
            end
            RX_DATA: begin
                // sampled at mid bit, one nominal period apart
                if (rx_q.cnt != '0) begin
                    rx_d.cnt = rx_q.cnt - 1'b1;
                end else begin
                    rx_d.shift = {rx_q.shift[shutdown_pkg::PRIO_W-2:0], line_in};
                    rx_d.cnt   = FULL_BIT;
                    if (rx_q.bit_idx == LAST_IDX) begin
                        rx_d.state = RX_IDLE;
                        rx_d.valid = 1'b1;
                        rx_d.value = {rx_q.shift[shutdown_pkg::PRIO_W-2:0], line_in};
                    end else begin
                        rx_d.bit_idx = rx_q.bit_idx + 1'b1;
                    end
                end
            end
        endcase
        if (!enable) begin
            rx_d.state = RX_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_q <= '{state: RX_IDLE, default: '0};
        end else begin
            rx_q <= rx_d;
        end
    end

    assign code_valid = rx_q.valid;
    assign code_value = rx_q.value;
endmodule

// file: rtl/emergency_port_shutdown.sv
// emergency port shutdown controller with axi4-lite registers
// What this block does
// - config bit selects single-bit or coded mode
// - set low-priority flag marks port low priority
// - single-bit mode never touches high-priority ports
// - rising edge powers off low-priority ports promptly
// - shutdown clears power request and enables, sets shed events
// - input high blocks low-priority power-on
// - coded mode keeps 3-bit priority per port
// - level 000 most important, 111 least
// - ports with level at or above code off
// - code bits last 24 to 26 us
// - coded shutdown completes within 50 us
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module emergency_port_shutdown #(
    parameter int unsigned NUM_PORTS  = shutdown_pkg::NUM_PORTS,
    parameter int unsigned BIT_CYCLES = shutdown_pkg::BIT_CYCLES
) (
    // clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // shutdown pin
    input  wire logic                    emergency_shutdown_input,
    // axi4-lite write address
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // per-port control towards the power state machines
    output logic [NUM_PORTS-1:0]         port_power_enable,
    output logic [NUM_PORTS-1:0]         port_detection_allow,
    output logic [NUM_PORTS-1:0]         port_classification_allow,
    output logic [NUM_PORTS-1:0]         port_forced_power_off
);
    localparam int unsigned PW = shutdown_pkg::PRIO_W;

    typedef struct packed {
        logic                        coded_priority_select;
        logic [NUM_PORTS-1:0]        port_low_priority_flag;
        logic [NUM_PORTS*PW-1:0]     port_priority_level;
        logic [NUM_PORTS-1:0]        power_req;
        logic [NUM_PORTS-1:0]        powered;
        logic [NUM_PORTS-1:0]        det_allow;
        logic [NUM_PORTS-1:0]        cls_allow;
        logic [NUM_PORTS-1:0]        shed_event;
        logic [NUM_PORTS-1:0]        forced_off;
        logic [PW-1:0]               last_code;
        logic                        pin_prev;
        logic                        aw_held;
        logic [7:0]                  aw_addr;
        logic                        w_held;
        logic [31:0]                 w_data;
        logic [3:0]                  w_strb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
    } state_type;

    state_type st_q;
    state_type st_d;
    logic                code_valid;
    logic [PW-1:0]       code_value;

    function automatic logic [NUM_PORTS-1:0] coded_victims(
        input logic [NUM_PORTS*PW-1:0] levels,
        input logic [PW-1:0]           code
    );
        logic [NUM_PORTS-1:0] hit;
        hit = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            // larger level means less important
            hit[i] = (levels[i*PW +: PW] >= code);
        end
        return hit;
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // coded receiver only listens in coded mode
    shutdown_code_receiver #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_rx (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .enable     (st_q.coded_priority_select),
        .line_in    (emergency_shutdown_input),
        .code_valid (code_valid),
        .code_value (code_value)
    );

    logic [NUM_PORTS-1:0] victims;
    logic [NUM_PORTS-1:0] blocked;
    logic                 pin_rise;
    logic                 do_write;
    logic [31:0]          wr_old;
    logic [31:0]          wr_val;
    logic                 wr_ok;
    logic [31:0]          rd_val;
    logic                 rd_ok;

    always_comb begin
        st_d          = st_q;
        st_d.pin_prev = emergency_shutdown_input;
        pin_rise      = emergency_shutdown_input && !st_q.pin_prev;
        victims       = '0;
        blocked       = '0;
        if (!st_q.coded_priority_select) begin
            // only flagged ports are affected
            if (pin_rise) begin
                victims = st_q.port_low_priority_flag & st_q.powered;
            end
            if (emergency_shutdown_input) begin
                blocked = st_q.port_low_priority_flag;
            end
        end else if (code_valid) begin
            // acted on the cycle after the last bit is sampled, far inside 50 us
            victims = coded_victims(st_q.port_priority_level, code_value) & st_q.powered;
        end
        if (code_valid) begin
            st_d.last_code = code_value;
        end

        // axi4-lite write
        wr_old   = '0;
        wr_ok    = 1'b1;
        do_write = 1'b0;
        if (s_axi_awvalid && !st_q.aw_held && !st_q.bvalid) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_held && !st_q.bvalid) begin
            st_d.w_held = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
            do_write     = 1'b1;
            st_d.aw_held = 1'b0;
            st_d.w_held  = 1'b0;
            st_d.bvalid  = 1'b1;
        end
        unique case (st_q.aw_addr)
            shutdown_pkg::ADDR_CONFIG:     wr_old = 32'(st_q.coded_priority_select);
            shutdown_pkg::ADDR_LOW_PRIO:   wr_old = 32'(st_q.port_low_priority_flag);
            shutdown_pkg::ADDR_PRIO_LEVEL: wr_old = 32'(st_q.port_priority_level);
            shutdown_pkg::ADDR_POWER_ON:   wr_old = 32'(st_q.power_req);
            shutdown_pkg::ADDR_ALLOW:      wr_old = {16'h0000, 8'(st_q.cls_allow),
                                                     8'(st_q.det_allow)};
            shutdown_pkg::ADDR_STATUS:     wr_old = '0;
            default:                       wr_ok  = 1'b0;
        endcase
        wr_val = merge(wr_old, st_q.w_data, st_q.w_strb);
        if (do_write) begin
            st_d.bresp = wr_ok ? shutdown_pkg::RESP_OKAY : shutdown_pkg::RESP_SLVERR;
            unique case (st_q.aw_addr)
                shutdown_pkg::ADDR_CONFIG:
                    st_d.coded_priority_select = wr_val[shutdown_pkg::CFG_CODED_BIT];
                shutdown_pkg::ADDR_LOW_PRIO:
                    st_d.port_low_priority_flag = wr_val[NUM_PORTS-1:0];
                shutdown_pkg::ADDR_PRIO_LEVEL:
                    st_d.port_priority_level = wr_val[NUM_PORTS*PW-1:0];
                shutdown_pkg::ADDR_POWER_ON:
                    st_d.power_req = wr_val[NUM_PORTS-1:0];
                shutdown_pkg::ADDR_ALLOW: begin
                    st_d.det_allow = wr_val[NUM_PORTS-1:0];
                    st_d.cls_allow = wr_val[8 +: NUM_PORTS];
                end
                // write-one-to-clear of shed events; a new shed below wins
                shutdown_pkg::ADDR_STATUS:
                    st_d.shed_event = st_q.shed_event & ~wr_val[NUM_PORTS-1:0];
                default: ;
            endcase
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        // axi4-lite read
        rd_val = '0;
        rd_ok  = 1'b1;
        unique case (s_axi_araddr)
            shutdown_pkg::ADDR_CONFIG:     rd_val = 32'(st_q.coded_priority_select);
            shutdown_pkg::ADDR_LOW_PRIO:   rd_val = 32'(st_q.port_low_priority_flag);
            shutdown_pkg::ADDR_PRIO_LEVEL: rd_val = 32'(st_q.port_priority_level);
            shutdown_pkg::ADDR_POWER_ON:   rd_val = {16'h0000, 8'(st_q.powered),
                                                     8'(st_q.power_req)};
            shutdown_pkg::ADDR_ALLOW:      rd_val = {16'h0000, 8'(st_q.cls_allow),
                                                     8'(st_q.det_allow)};
            shutdown_pkg::ADDR_STATUS:     rd_val = {16'h0000, 8'(st_q.forced_off),
                                                     8'(st_q.shed_event)};
            shutdown_pkg::ADDR_LAST_CODE:  rd_val = 32'(st_q.last_code);
            default:                       rd_ok  = 1'b0;
        endcase
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = rd_val;
            st_d.rresp  = rd_ok ? shutdown_pkg::RESP_OKAY : shutdown_pkg::RESP_SLVERR;
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        // port power control
        // power_req is the request; shedding drops it as a forced power-off does
        st_d.forced_off = victims;
        if (victims != '0) begin
            st_d.power_req  = st_d.power_req & ~victims;
            st_d.det_allow  = st_d.det_allow & ~victims;
            st_d.cls_allow  = st_d.cls_allow & ~victims;
            st_d.shed_event = st_d.shed_event | victims;
        end
        // no power-on without both enables; blocked ports stay off
        st_d.powered = st_d.power_req & st_d.det_allow & st_d.cls_allow & ~blocked
                       & (st_q.powered | ~victims);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready             = !st_q.aw_held && !st_q.bvalid;
    assign s_axi_wready              = !st_q.w_held && !st_q.bvalid;
    assign s_axi_bvalid              = st_q.bvalid;
    assign s_axi_bresp               = st_q.bresp;
    assign s_axi_arready             = !st_q.rvalid;
    assign s_axi_rvalid              = st_q.rvalid;
    assign s_axi_rdata               = st_q.rdata;
    assign s_axi_rresp               = st_q.rresp;
    assign port_power_enable         = st_q.powered;
    assign port_detection_allow      = st_q.det_allow;
    assign port_classification_allow = st_q.cls_allow;
    assign port_forced_power_off     = st_q.forced_off;
endmodule

// file: verif/emergency_port_shutdown_sva.sv
// assertion checker for the emergency port shutdown block
`timescale 1ns/1ps
module emergency_port_shutdown_sva #(
    parameter int unsigned NUM_PORTS  = 8,
    parameter int unsigned BIT_CYCLES = 6250
) (
    // clock and reset
    input wire logic                 aclk,
    input wire logic                 aresetn,
    // shutdown pin
    input wire logic                 emergency_shutdown_input,
    // register bus
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    // port control
    input wire logic [NUM_PORTS-1:0] port_power_enable,
    input wire logic [NUM_PORTS-1:0] port_detection_allow,
    input wire logic [NUM_PORTS-1:0] port_classification_allow,
    input wire logic [NUM_PORTS-1:0] port_forced_power_off
);
    // a coded frame ends about four bit periods after its first rising edge
    localparam int unsigned SHED_LIMIT = 4 * BIT_CYCLES + 8;
    logic        pin_q;
    logic [15:0] since_rise_q;
    always_ff @(posedge aclk) begin
        pin_q <= aresetn && emergency_shutdown_input;
        if (!aresetn)
            since_rise_q <= 16'hffff;
        else if (emergency_shutdown_input && !pin_q)
            since_rise_q <= 16'h0000;
        else if (since_rise_q != 16'hffff)
            since_rise_q <= since_rise_q + 16'h0001;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_shed_clears;
        |port_forced_power_off |=> ((port_power_enable | port_detection_allow
            | port_classification_allow) & $past(port_forced_power_off)) == '0;
    endproperty
    a_shed_clears: assert property (p_shed_clears) else $error("shed port left enabled");
    property p_shed_pulse;
        |port_forced_power_off |=> (port_forced_power_off & $past(port_forced_power_off)) == '0;
    endproperty
    a_shed_pulse: assert property (p_shed_pulse) else $error("shed pulse too long");
    property p_shed_cause;
        |port_forced_power_off |-> since_rise_q <= SHED_LIMIT;
    endproperty
    a_shed_cause: assert property (p_shed_cause) else $error("shed without pin activity");
    property p_power_allowed;
        (port_power_enable & ~$past(port_power_enable)
            & ~(port_detection_allow & port_classification_allow)) == '0;
    endproperty
    a_power_allowed: assert property (p_power_allowed) else $error("power without enables");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_refuse: assert property (p_wr_refuse) else $error("write taken during response");
    property p_rd_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rd_refuse: assert property (p_rd_refuse) else $error("read taken during answer");
    c_pin_rise: cover property (emergency_shutdown_input && !pin_q);
    c_shed: cover property (|port_forced_power_off);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind emergency_port_shutdown emergency_port_shutdown_sva #(
    .NUM_PORTS(NUM_PORTS), .BIT_CYCLES(BIT_CYCLES)
) emergency_port_shutdown_sva_inst (
    .aclk(aclk), .aresetn(aresetn), .emergency_shutdown_input(emergency_shutdown_input),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port_power_enable(port_power_enable),
    .port_detection_allow(port_detection_allow),
    .port_classification_allow(port_classification_allow),
    .port_forced_power_off(port_forced_power_off)
);

// file: verif/shutdown_host_model.sv
// host model driving the shutdown pin as a level or a coded frame
`timescale 1ns/1ps
module shutdown_host_model #(
    parameter int unsigned BIT_CYCLES = 20
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       level_req,
    input wire logic       send_req,
    input wire logic [2:0] code,
    output logic           line_out,
    output logic           busy
);
    logic [8:0]  shift_q;
    logic [15:0] cnt_q;
    logic [3:0]  slot_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy     <= 1'b0;
            line_out <= 1'b0;
            cnt_q    <= 16'h0000;
            slot_q   <= 4'h0;
        end else if (!busy) begin
            line_out <= level_req;
            if (send_req) begin
                // marker, three bits msb first, then five quiet bit periods
                busy     <= 1'b1;
                shift_q  <= {1'b1, code, 5'h00};
                line_out <= 1'b1;
                cnt_q    <= 16'h0000;
                slot_q   <= 4'h0;
            end
        end else if (cnt_q == 16'(BIT_CYCLES - 1)) begin
            cnt_q <= 16'h0000;
            if (slot_q == 4'h8) begin
                busy     <= 1'b0;
                line_out <= 1'b0;
            end else begin
                slot_q   <= slot_q + 4'h1;
                shift_q  <= shift_q << 1;
                line_out <= shift_q[7];
            end
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule

// file: verif/testbench.sv
// self-checking bench for the emergency port shutdown block
`timescale 1ns/1ps
module testbench;
    localparam int unsigned BITC = 20;
    logic aclk = 0, aresetn = 0, pin, busy, level_req = 0, send_req = 0;
    logic [2:0] code = 0;
    logic [7:0] awaddr = 0, araddr = 0, pwr, det, cls, shed;
    logic [31:0] wdata = 0, rdata, x = 32'h8ef2, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [7:0] lp, shed_acc;
    logic [23:0] lv;
    int mismatches = 0, checks_done = 0;
    initial forever #2 aclk = ~aclk;
    // shed pulses last one cycle; gather them so the bench can compare them
    always @(posedge aclk)
        shed_acc <= aresetn ? (shed_acc | shed) : 8'h00;
    emergency_port_shutdown #(.BIT_CYCLES(BITC)) emergency_port_shutdown_inst (
        .aclk(aclk), .aresetn(aresetn), .emergency_shutdown_input(pin),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_power_enable(pwr), .port_detection_allow(det),
        .port_classification_allow(cls), .port_forced_power_off(shed));
    shutdown_host_model #(.BIT_CYCLES(BITC)) shutdown_host_model_inst (
        .aclk(aclk), .aresetn(aresetn), .level_req(level_req), .send_req(send_req),
        .code(code), .line_out(pin), .busy(busy));
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // ports whose level is below the code stay powered
    function automatic logic [7:0] kept(input logic [23:0] l, input logic [2:0] c);
        for (int i = 0; i < 8; i++)
            kept[i] = l[3*i+:3] < c;
    endfunction
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        check_val({30'h0, got}, {30'h0, exp});
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic pa, pw, hb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        pa = 1;
        pw = 1;
        hb = 0;
        while (!hb) begin
            @(negedge aclk);
            hb = bvalid && !pa && !pw;
            rs = bresp;
            if (awready && awvalid) pa = 0;
            if (wready && wvalid) pw = 0;
            @(posedge aclk);
            if (!pa) awvalid <= 0;
            if (!pw) wvalid <= 0;
        end
        bready <= 0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic pa, hr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        pa = 1;
        hr = 0;
        while (!hr) begin
            @(negedge aclk);
            hr = rvalid && !pa;
            v = rdata;
            rs = rresp;
            if (arready && arvalid) pa = 0;
            @(posedge aclk);
            if (!pa) arvalid <= 0;
        end
        rready <= 0;
    endtask
    task automatic power_all;
        axi_write(shutdown_pkg::ADDR_ALLOW, 32'h0000_ffff, r);
        axi_write(shutdown_pkg::ADDR_POWER_ON, 32'h0000_00ff, r);
        repeat (4) @(posedge aclk);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        axi_read(shutdown_pkg::ADDR_CONFIG, d, r);
        check_val(d, 32'h0000_0000);
        axi_read(8'h1c, d, r);
        check_resp(r, shutdown_pkg::RESP_SLVERR);
        axi_write(8'h20, rnd(), r);
        check_resp(r, shutdown_pkg::RESP_SLVERR);
        lp = 8'(rnd()) | 8'h01;
        lp[7] = 1'b0;
        axi_write(shutdown_pkg::ADDR_LOW_PRIO, {24'h0, lp}, r);
        power_all;
        axi_read(shutdown_pkg::ADDR_POWER_ON, d, r);
        check_val({24'h0, d[15:8]}, 32'h0000_00ff);
        level_req <= 1;
        repeat (6) @(posedge aclk);
        check_val({24'h0, pwr}, {24'h0, ~lp});
        check_val({16'h0, det, cls}, {16'h0, ~lp, ~lp});
        check_val({24'h0, shed_acc}, {24'h0, lp});
        axi_read(shutdown_pkg::ADDR_STATUS, d, r);
        check_val({24'h0, d[7:0]}, {24'h0, lp});
        power_all;
        check_val({24'h0, pwr}, {24'h0, ~lp});
        level_req <= 0;
        repeat (4) @(posedge aclk);
        check_val({24'h0, pwr}, 32'h0000_00ff);
        axi_write(shutdown_pkg::ADDR_CONFIG, 32'h0000_0001, r);
        for (int c = 0; c < 8; c++) begin
            lv = 24'(rnd());
            if (c == 0) lv = 24'h00_0000;
            axi_write(shutdown_pkg::ADDR_PRIO_LEVEL, {8'h0, lv}, r);
            power_all;
            send_req <= 1;
            code <= 3'(c);
            @(posedge aclk);
            send_req <= 0;
            repeat (6 * BITC) @(posedge aclk);
            check_val({24'h0, pwr}, {24'h0, kept(lv, 3'(c))});
            axi_read(shutdown_pkg::ADDR_LAST_CODE, d, r);
            check_val(d, 32'(c));
            while (busy) @(posedge aclk);
        end
        close_out;
    end
endmodule
